// ===== hw/sync_barrier_cfg.svh
`ifndef SYNC_BARRIER_CFG_SVH
`define SYNC_BARRIER_CFG_SVH

// Mode and enable values held after reset
`define SBC_USER_MODE_RST 1'b0
`define SBC_EE_RST 1'b0
// Value of the user mode bit that selects supervisor mode
`define SBC_SUPERVISOR_MODE 1'b0
// Width of the operation kind code
`define SBC_OP_W 4

`endif

// ===== hw/sync_barrier_control.sv
// Behaviour
// - Interrupts except machine check, listed instructions: context
// - Start only after older exceptions reported
// - Older instructions finish in old context
// - System call/interrupt wait for higher priority
// - Context sync flushes and refetches younger
// - Context sync does not wait memory
// - Machine check bypasses sync; instruction side early
// - Execution sync: drain only, no refetch
// - State writes and memory sync: execution sync
// - Enable set with pending timer/external: take
// - Barrier and memory sync behave identically
// - Older accesses performed before younger accesses
// - Barrier architecturally orders accesses only
// - Memory sync holds younger until memory idle
// - Store then context sync: old fetch allowed
// - User mode bit 0 supervisor, 1 user
`include "sync_barrier_cfg.svh"

module sync_barrier_control (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic op_valid_i,
	input wire sync_barrier_pkg::sync_op_e op_kind_i,
	input wire logic op_user_mode_i,
	input wire logic op_ee_i,
	input wire logic older_drained_i,
	input wire logic mem_idle_i,
	input wire logic higher_irq_pend_i,
	input wire logic ext_pend_i,
	input wire logic mchk_data_i,
	input wire logic mchk_instr_i,
	output logic op_ready_o,
	output logic dispatch_stall_o,
	output logic mem_hold_o,
	output logic ctx_commit_o,
	output logic flush_o,
	output logic refetch_o,
	output logic irq_take_o,
	output logic mchk_take_o,
	output logic user_mode_o,
	output logic ee_o
);

	sync_barrier_pkg::sync_state_e state_reg;
	sync_barrier_pkg::sync_state_e state_next;
	sync_barrier_pkg::sync_op_e op_reg;
	logic is_ctx;
	logic is_exec;
	logic is_mem;
	logic needs_prio;
	logic writes_msr;
	logic new_user_reg;
	logic new_ee_reg;
	logic user_mode_reg;
	logic ee_reg;
	logic commit_reg;
	logic flush_reg;
	logic irq_take_reg;
	logic mchk_take_reg;
	logic accept;
	logic commit_go;
	logic ee_take;

	sync_op_classify classify_u (
		.op_i(op_reg),
		.is_ctx_o(is_ctx),
		.is_exec_o(is_exec),
		.is_mem_o(is_mem),
		.needs_prio_o(needs_prio),
		.writes_msr_o(writes_msr)
	);

	// No new op in the cycle a flush is being announced
	assign op_ready_o = (state_reg == sync_barrier_pkg::S_IDLE) && !flush_reg;
	assign accept = op_valid_i && op_ready_o &&
		(op_kind_i != sync_barrier_pkg::OP_NONE);
	// Instruction-side machine check must be reported before the op commits
	assign commit_go = (state_reg == sync_barrier_pkg::S_COMMIT) &&
		!mchk_instr_i;
	// Enable rising with a pending timer or external event
	assign ee_take = writes_msr && new_ee_reg && !ee_reg &&
		ext_pend_i;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sync_barrier_pkg::S_IDLE: begin
				if (accept) begin
					state_next = sync_barrier_pkg::S_DRAIN;
				end
			end
			sync_barrier_pkg::S_DRAIN: begin
				if (older_drained_i) begin
					if (is_mem) begin
						state_next = sync_barrier_pkg::S_MEM;
					end else if (needs_prio) begin
						state_next = sync_barrier_pkg::S_PRIO;
					end else begin
						// Context ops skip the memory wait
						state_next = sync_barrier_pkg::S_COMMIT;
					end
				end
			end
			sync_barrier_pkg::S_MEM: begin
				if (mem_idle_i) begin
					state_next = sync_barrier_pkg::S_COMMIT;
				end
			end
			sync_barrier_pkg::S_PRIO: begin
				if (!higher_irq_pend_i) begin
					state_next = sync_barrier_pkg::S_COMMIT;
				end
			end
			sync_barrier_pkg::S_COMMIT: begin
				if (commit_go) begin
					state_next = sync_barrier_pkg::S_IDLE;
				end
			end
			default: begin
				state_next = sync_barrier_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= sync_barrier_pkg::S_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_reg <= sync_barrier_pkg::OP_NONE;
			new_user_reg <= `SBC_USER_MODE_RST;
			new_ee_reg <= `SBC_EE_RST;
		end else if (accept) begin
			op_reg <= op_kind_i;
			new_user_reg <= op_user_mode_i;
			new_ee_reg <= op_ee_i;
		end
	end

	// Context changes land only after older work has drained
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			user_mode_reg <= `SBC_USER_MODE_RST;
			ee_reg <= `SBC_EE_RST;
		end else if (commit_go && writes_msr) begin
			user_mode_reg <= new_user_reg;
			ee_reg <= new_ee_reg;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			commit_reg <= 1'b0;
			flush_reg <= 1'b0;
			irq_take_reg <= 1'b0;
		end else begin
			commit_reg <= commit_go && is_exec;
			// Execution-only ops keep the younger stream unless ee_take flushes it
			flush_reg <= commit_go && (is_ctx || ee_take);
			irq_take_reg <= commit_go && ee_take;
		end
	end

	// Machine check is taken the next cycle and never waits for a drain
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mchk_take_reg <= 1'b0;
		end else begin
			mchk_take_reg <= mchk_data_i || mchk_instr_i;
		end
	end

	assign dispatch_stall_o =
		(state_reg != sync_barrier_pkg::S_IDLE);
	assign mem_hold_o = (state_reg == sync_barrier_pkg::S_MEM);
	assign ctx_commit_o = commit_reg;
	assign flush_o = flush_reg;
	assign refetch_o = flush_reg;
	assign irq_take_o = irq_take_reg;
	assign mchk_take_o = mchk_take_reg;
	assign user_mode_o = user_mode_reg;
	assign ee_o = ee_reg;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	drain_wait_a: assert property (
		(state_reg == sync_barrier_pkg::S_DRAIN && !older_drained_i)
		|=> state_reg == sync_barrier_pkg::S_DRAIN
	) else $error("sync op left drain before older work reported");

	mem_class_a: assert property (
		(state_reg == sync_barrier_pkg::S_DRAIN && older_drained_i &&
		(op_reg == sync_barrier_pkg::OP_MEM_BARRIER))
		|=> state_reg == sync_barrier_pkg::S_MEM ##0 mem_hold_o
	) else $error("barrier did not wait for older accesses");

	mem_wait_a: assert property (
		(state_reg == sync_barrier_pkg::S_MEM && !mem_idle_i)
		|=> dispatch_stall_o && mem_hold_o
	) else $error("memory sync released younger work too early");

	ctx_no_mem_a: assert property (
		(state_reg == sync_barrier_pkg::S_DRAIN && older_drained_i &&
		op_reg == sync_barrier_pkg::OP_CTX_SYNC)
		|=> state_reg == sync_barrier_pkg::S_COMMIT
	) else $error("context sync waited for memory");

	prio_hold_a: assert property (
		(state_reg == sync_barrier_pkg::S_PRIO && higher_irq_pend_i)
		|=> !ctx_commit_o ##0 state_reg == sync_barrier_pkg::S_PRIO
	) else $error("system call passed a higher priority interrupt");

	flush_ctx_a: assert property (
		(commit_go && op_reg == sync_barrier_pkg::OP_RET_IRQ)
		|=> flush_o && refetch_o && ctx_commit_o ##1 !flush_o
	) else $error("context sync did not flush and refetch once");

	exec_only_a: assert property (
		(commit_go && op_reg == sync_barrier_pkg::OP_MEM_SYNC)
		|=> ctx_commit_o && !flush_o && !irq_take_o
	) else $error("execution sync flushed the younger stream");

	ee_take_a: assert property (
		(commit_go && writes_msr && new_ee_reg && !ee_reg && ext_pend_i)
		|=> irq_take_o && flush_o && ee_o
	) else $error("pending interrupt not taken after enable");

	user_mode_a: assert property (
		(commit_go && writes_msr)
		|=> user_mode_o == $past(new_user_reg)
	) else $error("mode not taken from committed state write");

	mchk_a: assert property (
		(state_reg == sync_barrier_pkg::S_COMMIT && mchk_instr_i)
		|=> mchk_take_o && !ctx_commit_o
	) else $error("instruction machine check arrived after sync");

	stall_a: assert property (
		accept |=> dispatch_stall_o && !op_ready_o
	) else $error("dispatch not stalled by accepted sync op");

	commit_once_a: assert property (
		ctx_commit_o |=> !ctx_commit_o && !flush_o
	) else $error("commit pulse held longer than one cycle");

	flush_ready_a: assert property (
		flush_o |-> !op_ready_o && refetch_o
	) else $error("new op offered while younger stream flushes");

	old_ctx_a: assert property (
		!(commit_go && writes_msr)
		|=> $stable(user_mode_o) && $stable(ee_o)
	) else $error("context changed before older work drained");

	exec_drain_a: assert property (
		(state_reg == sync_barrier_pkg::S_DRAIN && older_drained_i &&
		op_reg == sync_barrier_pkg::OP_MSR_WRITE)
		|=> state_reg == sync_barrier_pkg::S_COMMIT
	) else $error("state write did not drain before commit");

	exec_keep_a: assert property (
		(commit_go && !ee_take &&
		op_reg == sync_barrier_pkg::OP_MSR_WRITE)
		|=> ctx_commit_o && !flush_o && !refetch_o
	) else $error("state write flushed younger stream");

	barrier_same_a: assert property (
		(commit_go && op_reg == sync_barrier_pkg::OP_MEM_BARRIER)
		|=> ctx_commit_o && !flush_o && !irq_take_o
	) else $error("barrier committed unlike memory sync");

	mchk_data_a: assert property (
		mchk_data_i |=> mchk_take_o
	) else $error("data machine check not passed through");

	ctx_cover: cover property (
		accept && op_kind_i == sync_barrier_pkg::OP_CTX_SYNC
		##[1:20] flush_o
	);

	msync_cover: cover property (
		state_reg == sync_barrier_pkg::S_MEM && !mem_idle_i
		##1 state_reg == sync_barrier_pkg::S_COMMIT
	);

	sc_prio_cover: cover property (
		state_reg == sync_barrier_pkg::S_PRIO && higher_irq_pend_i
		##[1:20] ctx_commit_o
	);

	ee_cover: cover property (irq_take_o);

endmodule // sync_barrier_control

// ===== hw/sync_barrier_pkg.sv
package sync_barrier_pkg;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_CTX_SYNC,
		OP_SYSTEM_CALL,
		OP_RET_IRQ,
		OP_RET_CRIT_IRQ,
		OP_RET_MCHK_IRQ,
		OP_MSR_WRITE,
		OP_EE_WRITE_REG,
		OP_EE_WRITE_IMM,
		OP_MEM_SYNC,
		OP_MEM_BARRIER,
		OP_INTERRUPT
	} sync_op_e;

	typedef enum {
		S_IDLE,
		S_DRAIN,
		S_MEM,
		S_PRIO,
		S_COMMIT
	} sync_state_e;

endpackage

// ===== hw/sync_op_classify.sv
module sync_op_classify (
	input wire sync_barrier_pkg::sync_op_e op_i,
	output logic is_ctx_o,
	output logic is_exec_o,
	output logic is_mem_o,
	output logic needs_prio_o,
	output logic writes_msr_o
);

	always_comb begin
		is_ctx_o = 1'b0;
		is_mem_o = 1'b0;
		needs_prio_o = 1'b0;
		writes_msr_o = 1'b0;
		case (op_i)
			sync_barrier_pkg::OP_CTX_SYNC: begin
				is_ctx_o = 1'b1;
			end
			sync_barrier_pkg::OP_SYSTEM_CALL,
			sync_barrier_pkg::OP_INTERRUPT: begin
				is_ctx_o = 1'b1;
				needs_prio_o = 1'b1;
				writes_msr_o = 1'b1;
			end
			sync_barrier_pkg::OP_RET_IRQ,
			sync_barrier_pkg::OP_RET_CRIT_IRQ,
			sync_barrier_pkg::OP_RET_MCHK_IRQ: begin
				is_ctx_o = 1'b1;
				writes_msr_o = 1'b1;
			end
			sync_barrier_pkg::OP_MSR_WRITE,
			sync_barrier_pkg::OP_EE_WRITE_REG,
			sync_barrier_pkg::OP_EE_WRITE_IMM: begin
				writes_msr_o = 1'b1;
			end
			// Barrier built as strong as memory sync: simpler, never wrong
			sync_barrier_pkg::OP_MEM_SYNC,
			sync_barrier_pkg::OP_MEM_BARRIER: begin
				is_mem_o = 1'b1;
			end
			default: begin
				is_ctx_o = 1'b0;
			end
		endcase
		// Every synchronizing kind drains older work
		is_exec_o = (op_i != sync_barrier_pkg::OP_NONE);
	end

endmodule // sync_op_classify

// ===== test/sync_barrier_control_tb.sv
module sync_barrier_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_n_i = 0, op_valid_i = 0, op_user_mode_i = 0;
	logic op_ee_i = 0, ext_pend_i = 0, mchk_data_i = 0, mchk_instr_i = 0;
	sync_barrier_pkg::sync_op_e op_kind_i = sync_barrier_pkg::OP_NONE;
	logic older_drained_i, mem_idle_i, higher_irq_pend_i, exp_mchk = 0;
	logic op_ready_o, dispatch_stall_o, mem_hold_o, ctx_commit_o, flush_o;
	logic refetch_o, irq_take_o, mchk_take_o, user_mode_o, ee_o;
	logic [2:0] lat = 3'h0;
	int err_total = 0;
	int comparisons = 0;
	always #5 clk_i = ~clk_i;
	sync_barrier_control u_sync_barrier_control (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_kind_i(op_kind_i),
		.op_user_mode_i(op_user_mode_i), .op_ee_i(op_ee_i),
		.older_drained_i(older_drained_i), .mem_idle_i(mem_idle_i),
		.higher_irq_pend_i(higher_irq_pend_i), .ext_pend_i(ext_pend_i),
		.mchk_data_i(mchk_data_i), .mchk_instr_i(mchk_instr_i),
		.op_ready_o(op_ready_o), .dispatch_stall_o(dispatch_stall_o),
		.mem_hold_o(mem_hold_o), .ctx_commit_o(ctx_commit_o),
		.flush_o(flush_o), .refetch_o(refetch_o), .irq_take_o(irq_take_o),
		.mchk_take_o(mchk_take_o), .user_mode_o(user_mode_o), .ee_o(ee_o));
	sync_partner_model u_sync_partner_model (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .stall_i(dispatch_stall_o), .lat_i(lat),
		.older_drained_o(older_drained_i), .mem_idle_o(mem_idle_i),
		.higher_irq_pend_o(higher_irq_pend_i));
	task automatic tally_and_finish;
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string name, input logic seen, input logic exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %b seen %b", name, exp, seen);
		end
	endtask
	// Kind codes: 1-5 and 11 context, 6-8 state writes, 9-10 memory
	function automatic logic [3:0] cls(input sync_barrier_pkg::sync_op_e k);
		logic c, m, p, l;
		c = (k >= 4'h1 && k <= 4'h5) || k == 4'hb;
		m = k == 4'h9 || k == 4'ha;
		p = k == 4'h2 || k == 4'hb;
		l = (k >= 4'h2 && k <= 4'h6) || k == 4'hb;
		return {c, m, p, l};
	endfunction
	task automatic do_op(input sync_barrier_pkg::sync_op_e k, input logic um,
		input logic ee, input logic ext);
		int n;
		logic [3:0] c;
		logic tk, fl, hold, ee0;
		n = 0;
		while (op_ready_o !== 1'b1 && n < 8) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		c = cls(k);
		ee0 = ee_o;
		tk = (c[0] || k == 4'h7 || k == 4'h8) && ee && !ee0 && ext;
		fl = c[3] | tk;
		lat = 3'($urandom_range(4));
		op_valid_i = 1;
		op_kind_i = k;
		op_user_mode_i = um;
		op_ee_i = ee;
		ext_pend_i = ext;
		@(posedge clk_i);
		#1;
		op_valid_i = 0;
		n = 1;
		hold = 0;
		while (ctx_commit_o !== 1'b1 && n < 80) begin
			hold |= mem_hold_o;
			check("stall", dispatch_stall_o, 1);
			@(posedge clk_i);
			#1;
			n++;
		end
		check("commit", ctx_commit_o, 1);
		check("latency", n >= lat + 3 + 2 * c[2] + 3 * c[1], 1);
		check("memhold", hold, c[2]);
		check("flush", flush_o, fl);
		check("refetch", refetch_o, fl);
		check("irqtake", irq_take_o, tk);
		check("ready", op_ready_o, !fl);
		check("stall_end", dispatch_stall_o, 0);
		if (c[0])
			check("mode", user_mode_o, um);
		check("ee", ee_o, (c[0] || k == 4'h7 || k == 4'h8) ? ee : ee0);
	endtask
	always @(posedge clk_i) begin
		#1;
		mchk_data_i = $urandom_range(3) == 0;
		mchk_instr_i = $urandom_range(15) == 0;
	end
	always @(posedge clk_i)
		exp_mchk <= rst_n_i & (mchk_data_i | mchk_instr_i);
	always @(negedge clk_i)
		if (rst_n_i)
			check("mchk", mchk_take_o, exp_mchk);
	initial begin
		#200000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h0067));
		repeat (20) @(posedge clk_i);
		#1;
		check("rst_ready", op_ready_o, 1);
		check("rst_mode", user_mode_o, 0);
		check("rst_ee", ee_o, 0);
		rst_n_i = 1;
		// An empty kind must never be taken
		op_valid_i = 1;
		repeat (3) @(posedge clk_i);
		#1;
		check("none", dispatch_stall_o, 0);
		op_valid_i = 0;
		for (int i = 1; i < 12; i++)
			do_op(sync_barrier_pkg::sync_op_e'(i), 1'($urandom_range(1)),
				1'($urandom_range(1)), 1'($urandom_range(1)));
		do_op(sync_barrier_pkg::OP_EE_WRITE_IMM, 0, 0, 1);
		do_op(sync_barrier_pkg::OP_EE_WRITE_IMM, 0, 1, 1);
		do_op(sync_barrier_pkg::OP_MSR_WRITE, 1, 1, 1);
		do_op(sync_barrier_pkg::OP_MEM_SYNC, 0, 0, 0);
		do_op(sync_barrier_pkg::OP_MEM_SYNC, 0, 0, 0);
		do_op(sync_barrier_pkg::OP_CTX_SYNC, 0, 0, 0);
		// Reset mid-run must drop the committed context
		rst_n_i = 0;
		repeat (2) @(posedge clk_i);
		#1;
		check("mid_mode", user_mode_o, 0);
		check("mid_ee", ee_o, 0);
		check("mid_ready", op_ready_o, 1);
		check("mid_stall", dispatch_stall_o, 0);
		rst_n_i = 1;
		do_op(sync_barrier_pkg::OP_MSR_WRITE, 0, 0, 0);
		do_op(sync_barrier_pkg::OP_CTX_SYNC, 0, 0, 0);
		do_op(sync_barrier_pkg::OP_MEM_SYNC, 0, 0, 0);
		repeat (50)
			do_op(sync_barrier_pkg::sync_op_e'($urandom_range(11, 1)),
				1'($urandom_range(1)), 1'($urandom_range(1)),
				1'($urandom_range(1)));
		tally_and_finish();
	end
endmodule // sync_barrier_control_tb

// ===== test/sync_partner_model.sv
module sync_partner_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic stall_i,
	input wire logic [2:0] lat_i,
	output logic older_drained_o,
	output logic mem_idle_o,
	output logic higher_irq_pend_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_reg;
	logic [3:0] lat;
	assign lat = {1'b0, lat_i};
	// Counts only while dispatch is held
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			wait_reg <= 4'h0;
		else if (!stall_i)
			wait_reg <= 4'h0;
		else if (wait_reg != 4'hf)
			wait_reg <= wait_reg + 4'h1;
	end
	// Late answers stress each wait state
	assign older_drained_o = wait_reg >= lat;
	assign mem_idle_o = wait_reg >= lat + 4'h2;
	assign higher_irq_pend_o = wait_reg < lat + 4'h3;
endmodule // sync_partner_model
